/* logic/lamie_core.sv */
// Notes on behaviour
// - Or-literal ORs accumulator with literal, one cycle.
// - Or-file ORs accumulator with file register.
// - Destination bit picks accumulator or file register.
// - Or and move-file update only negative, zero.
// - Access bit picks fixed bank or bank selector.
// - Extended set, access bit clear, low file field: indexed offset mode.
// - Pointer load: high part first, low second.
// - Move-file copies file register to destination.
// - Move-any copies 12-bit source to 12-bit destination.
// - Move-any reads first cycle, writes second Q4.
// - Bank load keeps upper four bits zero.
// - Load-literal sets accumulator, flags unchanged.
// - Store writes accumulator to file, no flags.
module lamie_core #(
	parameter logic [lamie_pkg::LAMIE_AW-1:0] ACC_ADDR = 12'hfe8
) (
	// Clock, reset and enable.
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic ce,
	// Instruction stream.
	input wire logic instr_valid,
	input wire logic [lamie_pkg::LAMIE_IW-1:0] instr_word,
	output logic instr_ready,
	// Data memory.
	output logic mem_re,
	output logic [lamie_pkg::LAMIE_AW-1:0] mem_raddr,
	input wire logic [lamie_pkg::LAMIE_DW-1:0] mem_rdata,
	output logic mem_we,
	output logic [lamie_pkg::LAMIE_AW-1:0] mem_waddr,
	output logic [lamie_pkg::LAMIE_DW-1:0] mem_wdata,
	// Wishbone slave.
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o
);
	import lamie_pkg::*;

	lamie_phase_t ph_r;
	lamie_step_t step_r;
	lamie_kind_t kind_r;
	lamie_kind_t kind_dec;
	logic [LAMIE_IW-1:0] ir_r;
	logic [LAMIE_AW-1:0] addr_r;
	logic [LAMIE_DW-1:0] acc_r;
	logic [LAMIE_DW-1:0] res_r;
	logic [LAMIE_DW-1:0] res_nxt;
	logic [LAMIE_HI_W-1:0] bank_r;
	logic [LAMIE_AW-1:0] fp_r [LAMIE_NPTR];
	logic [1:0] psel_r;
	logic flag_n_r;
	logic flag_z_r;
	logic ext_en_r;
	logic mem_re_r;
	logic mem_we_r;
	logic [LAMIE_AW-1:0] mem_waddr_r;
	logic [LAMIE_DW-1:0] mem_wdata_r;
	logic ack_r;
	logic [31:0] dat_r;

	// Phase strobes.
	wire accept = ce && ph_r == LAMIE_Q1 && instr_valid;
	wire q3 = ce && ph_r == LAMIE_Q3;
	wire q4 = ce && ph_r == LAMIE_Q4;
	wire first = step_r == LAMIE_STEP_ONE;

	// Instruction fields.
	wire [7:0] f_fld = instr_word[7:0];
	wire a_bit = instr_word[LAMIE_A_BIT];
	wire d_r = ir_r[LAMIE_D_BIT];
	wire [7:0] op8 = instr_word[LAMIE_OP8_LSB +: 8];
	wire [6:0] op7 = instr_word[LAMIE_OP7_LSB +: 7];
	wire [5:0] op6 = instr_word[LAMIE_OP6_LSB +: 6];
	wire [3:0] op4 = instr_word[LAMIE_OP4_LSB +: 4];
	wire [9:0] op10 = instr_word[LAMIE_OP10_LSB +: 10];

	// Decode of a first word.
	always_comb begin
		if (op8 == LAMIE_OP_OR_LIT)
			kind_dec = LAMIE_K_OR_LIT;
		else if (op6 == LAMIE_OP_OR_FILE)
			kind_dec = LAMIE_K_OR_FILE;
		else if (op6 == LAMIE_OP_MOVE_FILE)
			kind_dec = LAMIE_K_MOVE_FILE;
		else if (op7 == LAMIE_OP_STORE_ACC)
			kind_dec = LAMIE_K_STORE_ACC;
		else if (op8 == LAMIE_OP_BANK_LIT)
			kind_dec = LAMIE_K_BANK_LIT;
		else if (op8 == LAMIE_OP_ACC_LIT)
			kind_dec = LAMIE_K_ACC_LIT;
		else if (op4 == LAMIE_OP_ANY_SRC)
			kind_dec = LAMIE_K_ANY;
		else if (op10 == LAMIE_OP_PTR_LIT)
			kind_dec = LAMIE_K_PTR;
		else
			kind_dec = LAMIE_K_NONE;
	end

	// Effective file address for byte-oriented instructions.
	wire idx_mode = !a_bit && ext_en_r && f_fld <= LAMIE_IDX_LIMIT;
	wire [LAMIE_AW-1:0] idx_addr = fp_r[2] + {4'h0, f_fld};
	wire [3:0] acc_page = (f_fld < LAMIE_ACC_SPLIT) ? LAMIE_ACC_LO_PAGE :
		LAMIE_ACC_HI_PAGE;
	wire [LAMIE_AW-1:0] bank_addr = a_bit ? {bank_r, f_fld} :
		{acc_page, f_fld};
	wire [LAMIE_AW-1:0] file_addr = idx_mode ? idx_addr : bank_addr;
	wire [LAMIE_AW-1:0] any_addr = instr_word[LAMIE_AW-1:0];
	wire [LAMIE_AW-1:0] eff_addr = (!first || kind_dec == LAMIE_K_ANY) ?
		any_addr : file_addr;
	wire need_read = first && (kind_dec == LAMIE_K_OR_FILE ||
		kind_dec == LAMIE_K_MOVE_FILE || kind_dec == LAMIE_K_ANY);

	// The accumulator is also a data space location, so it is read here
	// rather than through memory to avoid a stale copy.
	wire at_acc = addr_r == ACC_ADDR;
	wire [LAMIE_DW-1:0] rd_val = at_acc ? acc_r : mem_rdata;

	always_comb begin
		case (kind_r)
			LAMIE_K_OR_LIT: res_nxt = acc_r | ir_r[7:0];
			LAMIE_K_OR_FILE: res_nxt = acc_r | rd_val;
			LAMIE_K_MOVE_FILE: res_nxt = rd_val;
			LAMIE_K_STORE_ACC: res_nxt = acc_r;
			LAMIE_K_ACC_LIT: res_nxt = ir_r[7:0];
			LAMIE_K_ANY: res_nxt = rd_val;
			default: res_nxt = res_r;
		endcase
	end

	// Routing of the result.
	wire nz_kind = kind_r == LAMIE_K_OR_LIT || kind_r == LAMIE_K_OR_FILE ||
		kind_r == LAMIE_K_MOVE_FILE;
	wire file_kind = kind_r == LAMIE_K_OR_FILE ||
		kind_r == LAMIE_K_MOVE_FILE;
	wire any2 = step_r == LAMIE_STEP_ANY2;
	wire to_mem = (file_kind && d_r) || kind_r == LAMIE_K_STORE_ACC ||
		any2;
	wire to_acc = kind_r == LAMIE_K_OR_LIT || kind_r == LAMIE_K_ACC_LIT ||
		(file_kind && !d_r) || (to_mem && at_acc);
	wire acc_wr = q4 && (first || any2) && to_acc;
	wire flag_wr = q4 && first && nz_kind;

	// Phase sequence, stalled at the first phase until a word arrives.
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n)
			ph_r <= LAMIE_Q1;
		else if (ce && (ph_r != LAMIE_Q1 || instr_valid))
			ph_r <= lamie_phase_t'(ph_r + 2'd1);
	end

	// Decode phase captures the word and its address.
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			ir_r <= '0;
			kind_r <= LAMIE_K_NONE;
			addr_r <= '0;
		end else if (accept) begin
			ir_r <= instr_word;
			addr_r <= eff_addr;
			if (first)
				kind_r <= kind_dec;
		end
	end

	// Read request stands for the second phase only; the second word of a
	// move-any issues none.
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n)
			mem_re_r <= 1'b0;
		else if (ce)
			mem_re_r <= accept && need_read;
	end

	// Process phase; move-any keeps its source byte for the next cycle.
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n)
			res_r <= '0;
		else if (q3 && first)
			res_r <= res_nxt;
	end

	// Memory write stands for the fourth phase.
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			mem_we_r <= 1'b0;
			mem_waddr_r <= '0;
			mem_wdata_r <= '0;
		end else if (ce) begin
			mem_we_r <= q3 && (first || any2) && to_mem && !at_acc;
			if (q3) begin
				mem_waddr_r <= addr_r;
				mem_wdata_r <= any2 ? res_r : res_nxt;
			end
		end
	end

	// Two-word sequencing.
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n)
			step_r <= LAMIE_STEP_ONE;
		else if (q4 && first && kind_r == LAMIE_K_PTR)
			step_r <= LAMIE_STEP_PTR2;
		else if (q4 && first && kind_r == LAMIE_K_ANY)
			step_r <= LAMIE_STEP_ANY2;
		else if (q4)
			step_r <= LAMIE_STEP_ONE;
	end

	// Bus write decode; the core wins over software in the same cycle.
	wire bus_req = wb_cyc_i && wb_stb_i && !ack_r;
	wire bus_wr = bus_req && wb_we_i && wb_sel_i[0];
	wire wr_acc_bus = bus_wr && wb_adr_i == LAMIE_REG_ACC;
	wire wr_bank_bus = bus_wr && wb_adr_i == LAMIE_REG_BANK;
	wire wr_ctrl_bus = bus_wr && wb_adr_i == LAMIE_REG_CTRL;
	wire bank_wr = q4 && first && kind_r == LAMIE_K_BANK_LIT;

	// Read data is gone by the fourth phase; write the held result.
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n)
			acc_r <= LAMIE_ACC_RST;
		else if (acc_wr)
			acc_r <= res_r;
		else if (ce && wr_acc_bus)
			acc_r <= wb_dat_i[LAMIE_DW-1:0];
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			flag_n_r <= 1'b0;
			flag_z_r <= 1'b0;
		end else if (flag_wr) begin
			flag_n_r <= res_r[LAMIE_DW-1];
			flag_z_r <= res_r == '0;
		end
	end

	// Only a low nibble is stored, so the upper bits cannot become set.
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n)
			bank_r <= LAMIE_BANK_RST;
		else if (bank_wr)
			bank_r <= ir_r[LAMIE_HI_W-1:0];
		else if (ce && wr_bank_bus)
			bank_r <= wb_dat_i[LAMIE_HI_W-1:0];
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			ext_en_r <= 1'b0;
			psel_r <= 2'd0;
		end else if (ce) begin
			if (wr_ctrl_bus)
				ext_en_r <= wb_dat_i[LAMIE_CTRL_EXT_BIT];
			if (q4 && first && kind_r == LAMIE_K_PTR)
				psel_r <= ir_r[LAMIE_PSEL_LSB +: 2];
		end
	end

	// File pointers: high part in the first cycle, low byte in the second.
	for (genvar i = 0; i < LAMIE_NPTR; i++) begin : g_ptr
		wire hi_wr = q4 && first && kind_r == LAMIE_K_PTR &&
			ir_r[LAMIE_PSEL_LSB +: 2] == 2'(i);
		wire lo_wr = q4 && step_r == LAMIE_STEP_PTR2 && psel_r == 2'(i);
		always_ff @(posedge clk_sys or negedge rst_n) begin
			if (!rst_n)
				fp_r[i] <= LAMIE_PTR_RST;
			else if (hi_wr)
				fp_r[i][LAMIE_AW-1 -: LAMIE_HI_W] <=
					ir_r[LAMIE_HI_W-1:0];
			else if (lo_wr)
				fp_r[i][LAMIE_DW-1:0] <= ir_r[LAMIE_DW-1:0];
		end
	end

	// Bus read selection; unmapped offsets read as zero and still ack.
	wire [31:0] rd_flags = 32'(({flag_n_r, flag_z_r} << LAMIE_FLAG_Z_BIT) |
		(32'(!first) << LAMIE_FLAG_BUSY_BIT));
	wire [31:0] rd_mux =
		(wb_adr_i == LAMIE_REG_ACC) ? 32'(acc_r) :
		(wb_adr_i == LAMIE_REG_FLAGS) ? rd_flags :
		(wb_adr_i == LAMIE_REG_BANK) ? 32'(bank_r) :
		(wb_adr_i == LAMIE_REG_CTRL) ? 32'(ext_en_r) :
		(wb_adr_i == LAMIE_REG_PTR0) ? 32'(fp_r[0]) :
		(wb_adr_i == LAMIE_REG_PTR1) ? 32'(fp_r[1]) :
		(wb_adr_i == LAMIE_REG_PTR2) ? 32'(fp_r[2]) : 32'h0000_0000;

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			ack_r <= 1'b0;
			dat_r <= '0;
		end else if (ce) begin
			ack_r <= bus_req;
			if (bus_req)
				dat_r <= rd_mux;
		end
	end

	assign instr_ready = ce && ph_r == LAMIE_Q1;
	assign mem_re = mem_re_r;
	assign mem_raddr = addr_r;
	assign mem_we = mem_we_r;
	assign mem_waddr = mem_waddr_r;
	assign mem_wdata = mem_wdata_r;
	assign wb_ack_o = ack_r;
	assign wb_dat_o = dat_r;

	default clocking lamie_cb @(posedge clk_sys);
	endclocking
	default disable iff (!rst_n);

	or_literal_a: assert property (
		q4 && first && kind_r == LAMIE_K_OR_LIT |=>
		acc_r == ($past(acc_r) | $past(ir_r[7:0])))
		else $error("or-literal result wrong");
	or_dest_a: assert property (
		q3 && kind_r == LAMIE_K_OR_FILE && !d_r && !at_acc |=> !mem_we_r)
		else $error("or-file with d=0 wrote memory");
	file_dest_a: assert property (
		q3 && file_kind && d_r && !at_acc |=>
		mem_we_r && mem_wdata_r == $past(res_nxt) ##1 !mem_we_r)
		else $error("file destination write wrong");
	nz_flags_a: assert property (
		flag_wr |=> flag_n_r == $past(res_r[7]) &&
		flag_z_r == ($past(res_r) == 8'h00))
		else $error("negative or zero flag wrong");
	flags_hold_a: assert property (
		q4 && !nz_kind |=> $stable(flag_n_r) && $stable(flag_z_r))
		else $error("flags changed by a flagless instruction");
	bank_upper_a: assert property (
		ack_r && $past(wb_adr_i) == LAMIE_REG_BANK |-> dat_r[7:4] == 4'h0)
		else $error("bank selector upper bits set");
	bank_addr_a: assert property (
		accept && first && need_read && kind_dec != LAMIE_K_ANY && a_bit |=>
		addr_r == {$past(bank_r), $past(f_fld)})
		else $error("banked address wrong");
	idx_addr_a: assert property (
		accept && first && need_read && kind_dec != LAMIE_K_ANY &&
		idx_mode |=> addr_r == $past(fp_r[2]) + {4'h0, $past(f_fld)})
		else $error("indexed offset address wrong");
	ptr_high_a: assert property (
		q4 && first && kind_r == LAMIE_K_PTR && ir_r[5:4] == 2'd2 |=>
		fp_r[2][11:8] == $past(ir_r[3:0]))
		else $error("pointer high part wrong");
	any_write_a: assert property (
		accept && any2 |=> !mem_re_r ##1 !mem_re_r ##1
		mem_we_r == !at_acc && mem_wdata_r == res_r)
		else $error("move-any second cycle wrong");
	phase_order_a: assert property (
		ce && ph_r == LAMIE_Q2 |=> ph_r == LAMIE_Q3)
		else $error("phase order broken");

	any_cov: cover property (q4 && any2 && mem_we_r);
	ptr_cov: cover property (q4 && step_r == LAMIE_STEP_PTR2);
	or_lit_cov: cover property (flag_wr && kind_r == LAMIE_K_OR_LIT);
	idx_cov: cover property (accept && need_read && idx_mode);

endmodule // lamie_core

/* logic/lamie_pkg.sv */
package lamie_pkg;

	// Data, address and instruction widths.
	localparam int LAMIE_DW = 8;
	localparam int LAMIE_AW = 12;
	localparam int LAMIE_IW = 16;
	localparam int LAMIE_NPTR = 3;

	// Opcode prefixes, each compared at its own field position, except LAMIE_OP_ANY_DST, which the core never decodes.
	localparam logic [7:0] LAMIE_OP_OR_LIT = 8'h09;
	localparam logic [7:0] LAMIE_OP_BANK_LIT = 8'h01;
	localparam logic [7:0] LAMIE_OP_ACC_LIT = 8'h0e;
	localparam logic [5:0] LAMIE_OP_OR_FILE = 6'h04;
	localparam logic [5:0] LAMIE_OP_MOVE_FILE = 6'h14;
	localparam logic [6:0] LAMIE_OP_STORE_ACC = 7'h37;
	localparam logic [3:0] LAMIE_OP_ANY_SRC = 4'hc;
	localparam logic [3:0] LAMIE_OP_ANY_DST = 4'hf;
	localparam logic [9:0] LAMIE_OP_PTR_LIT = 10'h3b8;
	localparam int LAMIE_OP8_LSB = 8;
	localparam int LAMIE_OP7_LSB = 9;
	localparam int LAMIE_OP6_LSB = 10;
	localparam int LAMIE_OP4_LSB = 12;
	localparam int LAMIE_OP10_LSB = 6;
	localparam int LAMIE_D_BIT = 9;
	localparam int LAMIE_A_BIT = 8;
	localparam int LAMIE_PSEL_LSB = 4;
	localparam int LAMIE_HI_W = 4;

	// Data space mapping.
	localparam logic [7:0] LAMIE_IDX_LIMIT = 8'h5f;
	localparam logic [7:0] LAMIE_ACC_SPLIT = 8'h80;
	localparam logic [3:0] LAMIE_ACC_LO_PAGE = 4'h0;
	localparam logic [3:0] LAMIE_ACC_HI_PAGE = 4'hf;

	// Register byte offsets on the bus.
	localparam logic [7:0] LAMIE_REG_ACC = 8'h00;
	localparam logic [7:0] LAMIE_REG_FLAGS = 8'h04;
	localparam logic [7:0] LAMIE_REG_BANK = 8'h08;
	localparam logic [7:0] LAMIE_REG_CTRL = 8'h0c;
	localparam logic [7:0] LAMIE_REG_PTR0 = 8'h10;
	localparam logic [7:0] LAMIE_REG_PTR1 = 8'h14;
	localparam logic [7:0] LAMIE_REG_PTR2 = 8'h18;
	localparam int LAMIE_FLAG_Z_BIT = 0;
	localparam int LAMIE_FLAG_N_BIT = 1;
	localparam int LAMIE_FLAG_BUSY_BIT = 2;
	localparam int LAMIE_CTRL_EXT_BIT = 0;

	// Reset values.
	localparam logic [7:0] LAMIE_ACC_RST = 8'h00;
	localparam logic [3:0] LAMIE_BANK_RST = 4'h0;
	localparam logic [11:0] LAMIE_PTR_RST = 12'h000;

	typedef enum logic [1:0] {LAMIE_Q1, LAMIE_Q2, LAMIE_Q3, LAMIE_Q4}
		lamie_phase_t;
	typedef enum logic [1:0] {LAMIE_STEP_ONE, LAMIE_STEP_PTR2,
		LAMIE_STEP_ANY2} lamie_step_t;
	typedef enum logic [3:0] {LAMIE_K_NONE, LAMIE_K_OR_LIT, LAMIE_K_OR_FILE,
		LAMIE_K_MOVE_FILE, LAMIE_K_STORE_ACC, LAMIE_K_BANK_LIT,
		LAMIE_K_ACC_LIT, LAMIE_K_ANY, LAMIE_K_PTR} lamie_kind_t;

endpackage

/* tb/lamie_mem_model.sv */
module lamie_mem_model (
	// Clock.
	input wire logic clk_sys,
	// Read port.
	input wire logic mem_re,
	input wire logic [lamie_pkg::LAMIE_AW-1:0] mem_raddr,
	output logic [lamie_pkg::LAMIE_DW-1:0] mem_rdata,
	// Write port.
	input wire logic mem_we,
	input wire logic [lamie_pkg::LAMIE_AW-1:0] mem_waddr,
	input wire logic [lamie_pkg::LAMIE_DW-1:0] mem_wdata
);
	timeunit 1ns;
	timeprecision 1ps;
	import lamie_pkg::*;
	logic [LAMIE_DW-1:0] ram [4096];
	initial mem_rdata = 8'h00;
	// Read data stands one cycle, then turns to its inverse so that a late
	// sample by the core cannot pass by luck.
	always @(posedge clk_sys) begin
		mem_rdata <= mem_re ? ram[mem_raddr] : ~mem_rdata;
		if (mem_we) begin
			ram[mem_waddr] <= mem_wdata;
		end
	end
endmodule // lamie_mem_model

/* tb/tb_logic_and_move_instr_exec.sv */
module tb_logic_and_move_instr_exec;
	timeunit 1ns;
	timeprecision 1ps;
	import lamie_pkg::*;
	localparam logic [11:0] ACCA = 12'hfe8;
	logic clk_sys, rst_n, ce, instr_valid, instr_ready, mem_re, mem_we;
	logic wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, z, n, ext;
	logic [15:0] instr_word;
	logic [11:0] mem_raddr, mem_waddr;
	logic [7:0] mem_rdata, mem_wdata, wb_adr_i, acc;
	logic [3:0] wb_sel_i, bank;
	logic [31:0] wb_dat_i, wb_dat_o, q;
	logic [7:0] shm [4096];
	logic [11:0] ptr [3];
	logic [2:0] wm, rm;
	int errors, tests_run;
	logic [31:0] dir [16] = '{32'hee23f0ab, 32'h0e9a0000, 32'h09350000,
		32'h0e000000, 32'h09000000, 32'h09800000, 32'h01ff0000,
		32'h105f0000, 32'h10600000, 32'h13a00000, 32'h52e80000,
		32'h6ee80000, 32'h6f120000, 32'hc123f456, 32'hcfe8f100,
		32'hc100ffe8};
	lamie_core #(.ACC_ADDR(ACCA)) dut_u (.clk_sys(clk_sys), .rst_n(rst_n),
		.ce(ce), .instr_valid(instr_valid), .instr_word(instr_word),
		.instr_ready(instr_ready), .mem_re(mem_re), .mem_raddr(mem_raddr),
		.mem_rdata(mem_rdata), .mem_we(mem_we), .mem_waddr(mem_waddr),
		.mem_wdata(mem_wdata), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
		.wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
		.wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o));
	lamie_mem_model mem_u (.clk_sys(clk_sys), .mem_re(mem_re),
		.mem_raddr(mem_raddr), .mem_rdata(mem_rdata), .mem_we(mem_we),
		.mem_waddr(mem_waddr), .mem_wdata(mem_wdata));
	initial begin
		clk_sys = 1'b0;
		forever #4 clk_sys = ~clk_sys;
	end
	task automatic complete_run();
		$display("Checks %0d, mismatches %0d", tests_run, errors);
		if (errors == 0 && tests_run > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wb(input logic we, input logic [7:0] a,
		input logic [31:0] d, input logic [3:0] s);
		int i;
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= a;
		wb_dat_i <= d;
		wb_sel_i <= s;
		i = 0;
		do begin
			@(posedge clk_sys);
			i++;
		end while (wb_ack_o !== 1'b1 && i < 50);
		q = wb_dat_o;
		chk(32'(i < 50), 32'h1);
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		@(posedge clk_sys);
	endtask
	// Offers one word and records the memory strobes of the three phases
	// that follow the edge at which it was taken.
	task automatic issue(input logic [15:0] w);
		int i;
		instr_valid <= 1'b1;
		instr_word <= w;
		i = 0;
		do begin
			@(posedge clk_sys);
			i++;
		end while (instr_ready !== 1'b1 && i < 50);
		chk(32'(i < 50), 32'h1);
		instr_valid <= 1'b0;
		for (int c = 0; c < 3; c++) begin
			@(negedge clk_sys);
			wm[c] = mem_we;
			rm[c] = mem_re;
		end
		@(posedge clk_sys);
	endtask
	function automatic logic [11:0] ea(input logic a, input logic [7:0] f);
		if (a) return {bank, f};
		if (ext && f <= LAMIE_IDX_LIMIT) return ptr[2] + {4'h0, f};
		if (f < LAMIE_ACC_SPLIT) return {LAMIE_ACC_LO_PAGE, f};
		return {LAMIE_ACC_HI_PAGE, f};
	endfunction
	function automatic logic [7:0] rd(input logic [11:0] ad);
		return (ad == ACCA) ? acc : shm[ad];
	endfunction
	// The accumulator address never reaches memory, so no strobe is due.
	function automatic logic wr(input logic [11:0] ad, input logic [7:0] v);
		if (ad == ACCA) acc = v;
		else shm[ad] = v;
		return ad != ACCA;
	endfunction
	function automatic logic [31:0] exp_reg(input int k);
		case (k)
			0: return {24'h0, acc};
			1: return {30'h0, n, z};
			2: return {28'h0, bank};
			3: return {31'h0, ext};
			default: return {20'h0, ptr[k-4]};
		endcase
	endfunction
	task automatic regs_chk();
		for (int k = 0; k < 7; k++) begin
			wb(1'b0, 8'(k * 4), 32'h0, 4'h1);
			chk(q, exp_reg(k));
		end
	endtask
	task automatic step(input logic [15:0] w, input logic [15:0] w2);
		logic [11:0] ad;
		logic [7:0] r;
		logic we;
		ad = ea(w[8], w[7:0]);
		we = 1'b0;
		r = 8'h00;
		issue(w);
		casez (w[15:8])
			8'h09: r = acc | w[7:0];
			8'b0001_00??: r = acc | rd(ad);
			8'b0101_00??: r = rd(ad);
			8'b0110_111?: we = wr(ad, acc);
			8'h01: bank = w[3:0];
			8'h0e: acc = w[7:0];
			8'hee: ptr[w[5:4]][11:8] = w[3:0];
			default: ;
		endcase
		if (w[15:8] == LAMIE_OP_OR_LIT || w[15:10] == LAMIE_OP_OR_FILE ||
			w[15:10] == LAMIE_OP_MOVE_FILE) begin
			if (w[15:8] != 8'h09) chk({29'h0, rm}, 32'h1);
			z = (r == 8'h00);
			n = r[7];
			if (w[15:8] != 8'h09 && w[9]) we = wr(ad, r);
			else acc = r;
		end
		if (w[15:12] == 4'hc) begin
			chk({29'h0, wm}, 32'h0);
			chk({29'h0, rm}, 32'h1);
			issue(w2);
			chk({29'h0, rm}, 32'h0);
			we = wr(w2[11:0], rd(w[11:0]));
		end
		if (w[15:8] == 8'hee) begin
			issue(w2);
			ptr[w[5:4]][7:0] = w2[7:0];
		end
		chk({29'h0, wm}, {29'h0, we, 2'b00});
		regs_chk();
	endtask
	task automatic rand_step();
		logic [31:0] x;
		logic [31:0] y;
		logic [15:0] w;
		x = $urandom;
		y = $urandom;
		if (x[31:29] == 3'h0) begin
			wb(1'b1, LAMIE_REG_ACC, {24'h0, x[7:0]}, {3'h0, x[28]});
			if (x[28]) acc = x[7:0];
		end
		if (x[31:29] == 3'h1) begin
			wb(1'b1, LAMIE_REG_CTRL, {31'h0, x[28]}, 4'h1);
			ext = x[28];
		end
		case (x[27:25])
			3'h0: w = {LAMIE_OP_OR_LIT, y[7:0]};
			3'h1: w = {LAMIE_OP_OR_FILE, y[9:0]};
			3'h2: w = {LAMIE_OP_MOVE_FILE, y[9:0]};
			3'h3: w = {LAMIE_OP_STORE_ACC, y[8:0]};
			3'h4: w = {LAMIE_OP_BANK_LIT, y[7:0]};
			3'h5: w = {LAMIE_OP_ACC_LIT, y[7:0]};
			3'h6: w = {LAMIE_OP_ANY_SRC, y[11:0]};
			default: w = {LAMIE_OP_PTR_LIT,
				(y[5:4] == 2'h3) ? 2'h2 : y[5:4], y[3:0]};
		endcase
		step(w, {LAMIE_OP_ANY_DST, y[27:16]});
	endtask
	initial begin
		#400us;
		errors++;
		complete_run();
	end
	initial begin
		rst_n = 1'b0;
		ce = 1'b1;
		instr_valid = 1'b0;
		instr_word = 16'h0000;
		wb_cyc_i = 1'b0;
		wb_stb_i = 1'b0;
		wb_we_i = 1'b0;
		wb_adr_i = 8'h00;
		wb_sel_i = 4'h0;
		wb_dat_i = 32'h0;
		errors = 0;
		tests_run = 0;
		{acc, bank, z, n, ext} = '0;
		ptr = '{default: 12'h000};
		void'($urandom(23451));
		for (int i = 0; i < 4096; i++) begin
			shm[i] = 8'($urandom);
			mem_u.ram[i] = shm[i];
		end
		repeat (10) @(posedge clk_sys);
		rst_n <= 1'b1;
		@(posedge clk_sys);
		regs_chk();
		wb(1'b1, 8'h20, 32'hff, 4'h1);
		wb(1'b0, 8'h20, 32'h0, 4'h1);
		chk(q, 32'h0);
		$display("Test reset and map done");
		wb(1'b1, LAMIE_REG_CTRL, 32'h1, 4'h1);
		ext = 1'b1;
		foreach (dir[i]) begin
			step(dir[i][31:16], dir[i][15:0]);
		end
		ce <= 1'b0;
		repeat (5) @(posedge clk_sys);
		chk({31'h0, instr_ready}, 32'h0);
		ce <= 1'b1;
		step(16'h0e55, 16'h0000);
		$display("Test directed done");
		for (int i = 0; i < 300; i++) begin
			rand_step();
		end
		$display("Test random done");
		for (int a = 0; a < 4096; a++) begin
			chk({24'h0, mem_u.ram[a]}, {24'h0, shm[a]});
		end
		$display("Test memory sweep done");
		complete_run();
	end
endmodule // tb_logic_and_move_instr_exec
